// ==== src/tafr_top.sv ====
// tafr_top: exponential average of die sensor samples and the one-wire readout of that average.
// assumes samples and the wire level are synchronous to ref_clk; the wire idles low with a weak pull.
`timescale 1ns/1ps
module tafr_top
	import tafr_pkg::*;
(
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	// die temperature sensor
	input  wire tafr_pkg::tafr_sample_s         die_temp_sensor,
	input  wire logic                          thermal_limit_assert,
	// boot configuration
	input  wire logic                          shift_load,
	input  wire logic [tafr_pkg::SHIFT_W-1:0]  averaging_shift_constant,
	// readings
	output logic signed [tafr_pkg::TEMP_W-1:0] model_specific_register,
	output logic signed [tafr_pkg::AVG_W-1:0]  avg_temp,
	// thermal sideband wire
	input  wire logic                          thermal_sideband_wire_in,
	output tafr_pkg::tafr_link_s               thermal_sideband_wire
);
	import tafr_pkg::*;

	logic [SHIFT_W-1:0]       shift_q;
	logic signed [AVG_W-1:0]  avg_q;
	logic signed [TEMP_W-1:0] msr_q;
	logic                     seeded_q;
	tafr_state_e              state_q;
	tafr_state_e              state_d;
	logic [CNT_W-1:0]         cnt_q;
	logic [CNT_W-1:0]         cnt_d;
	logic [CNT_W-1:0]         period_q;
	logic [3:0]               bit_q;
	logic [WORD_W-1:0]        word_q;
	logic                     win_q;
	tafr_link_s               link_q;

	// sample conditioning: the throttle point reads as zero, cooler reads at least one
	wire logic signed [TEMP_W-1:0] samp_int = thermal_limit_assert ? '0 :
		(die_temp_sensor.temp < TEMP_W'(1)) ? TEMP_W'(1) : die_temp_sensor.temp;
	wire logic signed [AVG_W-1:0]  samp_fix = AVG_W'(samp_int) <<< FRAC_W;
	wire logic signed [AVG_W:0]    diff     = (AVG_W+1)'(samp_fix) - (AVG_W+1)'(avg_q);
	wire logic signed [AVG_W:0]    step     = diff >>> shift_q;
	// first sample seeds the average so a cold start cannot creep through (0,1)
	wire logic signed [AVG_W-1:0]  avg_d    = seeded_q ? avg_q + step[AVG_W-1:0] : samp_fix;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shift_q  <= SHIFT_DEF;
		end else if (shift_load) begin
			shift_q  <= averaging_shift_constant;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avg_q    <= AVG_RST;
			msr_q    <= '0;
			seeded_q <= 1'b0;
		end else if (die_temp_sensor.valid) begin
			avg_q    <= avg_d;
			msr_q    <= avg_d[AVG_W-1:FRAC_W];
			seeded_q <= 1'b1;
		end
	end

	assign model_specific_register = msr_q;
	assign avg_temp                = avg_q;

	// link: host gives two rising edges, their distance is the bit time of this message
	wire logic             rise    = thermal_sideband_wire_in & ~win_q;
	wire logic [CNT_W-1:0] hi0     = period_q >> 2;
	wire logic [CNT_W-1:0] hi1     = period_q - hi0;
	wire logic [CNT_W-1:0] hi_cur  = word_q[bit_q] ? hi1 : hi0;
	wire logic             bit_end = (cnt_q == period_q - CNT_W'(1));
	wire logic             go_tx   = !thermal_sideband_wire_in && bit_end;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + CNT_W'(1);
		unique case (state_q)
			TAFR_IDLE: begin
				cnt_d = CNT_W'(1);
				if (rise) begin
					state_d = TAFR_MEAS;
				end
			end
			TAFR_MEAS: begin
				if (rise) begin
					state_d = (cnt_q < PERIOD_MIN) ? TAFR_IDLE : TAFR_GAP;
					cnt_d   = '0;
				end else if (cnt_q == CNT_MAX) begin
					state_d = TAFR_IDLE;
				end
			end
			TAFR_GAP: begin
				// one quiet bit time after the host lets go, then answer
				if (thermal_sideband_wire_in) begin
					cnt_d = '0;
				end else if (go_tx) begin
					state_d = TAFR_TX;
					cnt_d   = '0;
				end
			end
			TAFR_TX: begin
				if (bit_end) begin
					cnt_d = '0;
					if (bit_q == 4'h0) begin
						state_d = TAFR_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q  <= TAFR_IDLE;
			cnt_q    <= '0;
			win_q    <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			win_q    <= thermal_sideband_wire_in;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			period_q <= '0;
			bit_q    <= BIT_LAST;
			word_q   <= '0;
		end else begin
			if (state_q == TAFR_MEAS && rise) begin
				period_q <= cnt_q;
			end
			if (state_q == TAFR_GAP && go_tx) begin
				word_q   <= WORD_W'(avg_q);
				bit_q    <= BIT_LAST;
			end else if (state_q == TAFR_TX && bit_end) begin
				bit_q    <= bit_q - 4'h1;
			end
		end
	end

	// bits go out msb first; high for a quarter (0) or three quarters (1) of the bit time
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			link_q <= '0;
		end else begin
			link_q.oe  <= (state_q == TAFR_TX);
			link_q.drv <= (state_q == TAFR_TX) && (cnt_q < hi_cur);
		end
	end

	assign thermal_sideband_wire = link_q;

	// checking helpers
	logic limit_seen_q;
	logic loaded_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			limit_seen_q <= 1'b0;
			loaded_q     <= 1'b0;
		end else begin
			limit_seen_q <= limit_seen_q | (thermal_limit_assert & die_temp_sensor.valid);
			loaded_q     <= loaded_q | shift_load;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_avg_update;
		die_temp_sensor.valid && seeded_q |=> avg_q == $past(avg_q) + $past(step[AVG_W-1:0]);
	endproperty
	a_avg_update: assert property (p_avg_update) else $error("average step wrong");

	property p_shift_default;
		!loaded_q |-> shift_q == SHIFT_DEF;
	endproperty
	a_shift_default: assert property (p_shift_default) else $error("shift not at default");

	property p_sample_floor;
		!thermal_limit_assert |-> samp_int >= TEMP_W'(1);
	endproperty
	a_sample_floor: assert property (p_sample_floor) else $error("cool sample below one");

	property p_msr_integer;
		die_temp_sensor.valid |=> model_specific_register == $past(avg_d[AVG_W-1:FRAC_W]);
	endproperty
	a_msr_integer: assert property (p_msr_integer) else $error("integer reading wrong");

	property p_tx_word;
		state_q == TAFR_GAP && go_tx |=> word_q == WORD_W'($past(avg_q)) && state_q == TAFR_TX;
	endproperty
	a_tx_word: assert property (p_tx_word) else $error("wire word is not the average");

	property p_frac_window;
		!limit_seen_q |-> !(avg_q > AVG_RST && avg_q < AVG_ONE);
	endproperty
	a_frac_window: assert property (p_frac_window) else $error("fraction without throttle");

	property p_bit_start;
		$rose(link_q.drv) |-> $past(cnt_q) == '0 && $past(state_q) == TAFR_TX;
	endproperty
	a_bit_start: assert property (p_bit_start) else $error("rise not at bit start");

	property p_bit_len;
		state_q == TAFR_TX |=> link_q.drv == ($past(cnt_q) < $past(hi_cur)) && link_q.oe;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bit high time wrong");

	property p_rate;
		state_q == TAFR_MEAS && rise && cnt_q >= PERIOD_MIN |=> period_q == $past(cnt_q) ##1 state_q != TAFR_MEAS;
	endproperty
	a_rate: assert property (p_rate) else $error("bit time not captured");

	property p_floor_round;
		die_temp_sensor.valid && seeded_q && diff < 0 |=> avg_q < $past(avg_q);
	endproperty
	a_floor_round: assert property (p_floor_round) else $error("negative step rounded to zero");

	c_message:   cover property (state_q == TAFR_TX && bit_q == 4'h0 && bit_end);
	c_fraction:  cover property (avg_q > AVG_RST && avg_q < AVG_ONE);
	c_reload:    cover property (shift_load ##2 die_temp_sensor.valid);
	c_abort:     cover property (state_q == TAFR_MEAS && cnt_q == CNT_MAX);
endmodule : tafr_top

// ==== src/tafr_pkg.sv ====
// tafr_pkg: constants and carrier types of the thermal average filter and its wire readout.
// assumes one core clock; the sample rate is set by whoever strobes the raw samples.
package tafr_pkg;
	// raw sample and average layout
	localparam int TEMP_W    = 8;                  // signed integer part
	localparam int FRAC_W    = 6;                  // fraction bits of the average
	localparam int AVG_W     = TEMP_W + FRAC_W;    // signed fixed point average
	localparam int SHIFT_W   = 4;
	localparam int WORD_W    = 16;                 // word returned on the wire
	// averaging window after reset
	localparam int AVG_WINDOW_MS     = 256;
	localparam int SAMPLE_PERIOD_MS  = 1;
	localparam logic [SHIFT_W-1:0] SHIFT_DEF = SHIFT_W'($clog2(AVG_WINDOW_MS / SAMPLE_PERIOD_MS));
	localparam logic signed [AVG_W-1:0] AVG_ONE = AVG_W'(1) <<< FRAC_W;
	localparam logic signed [AVG_W-1:0] AVG_RST = '0;
	// link timing
	localparam int CNT_W       = 16;
	localparam logic [CNT_W-1:0] PERIOD_MIN = 16'h0004;   // shortest bit time the encoder can split
	localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;   // rate measurement gives up here
	localparam logic [3:0]       BIT_LAST   = 4'hF;

	typedef enum logic [1:0] {
		TAFR_IDLE = 2'b00,
		TAFR_MEAS = 2'b01,
		TAFR_GAP  = 2'b10,
		TAFR_TX   = 2'b11
	} tafr_state_e;

	typedef struct packed {
		logic drv;   // level driven onto the wire
		logic oe;    // high while the block drives the wire
	} tafr_link_s;

	typedef struct packed {
		logic                     valid;
		logic signed [TEMP_W-1:0] temp;
	} tafr_sample_s;
endpackage : tafr_pkg

// ==== test/tafr_host_model.sv ====
// tafr_host_model: far-side monitor on the sideband wire; asks for the average and decodes it.
// assumes the bench resolves the wire: device drive while its enable is high, else this drive.
`timescale 1ns/1ps
module tafr_host_model (
	// clock
	input  wire logic ref_clk,
	// wire
	input  wire logic wire_lvl,
	output logic      host_drv
);
	initial host_drv = 1'b0;

	task automatic read_word(input int period, output logic [15:0] word, output logic ok);
		int n;
		int hi;
		ok = 1'b1;
		word = 16'h0000;
		@(negedge ref_clk);
		host_drv = 1'b1;
		repeat (2) @(negedge ref_clk);
		host_drv = 1'b0;
		repeat (period - 2) @(negedge ref_clk);
		host_drv = 1'b1; // second rise sets this message's bit time
		repeat (2) @(negedge ref_clk);
		host_drv = 1'b0; // released: the pull-down holds the wire low
		// let the released level settle before the first wait looks at the wire
		@(negedge ref_clk);
		for (int b = 15; b >= 0; b--) begin
			n = 0;
			hi = 0;
			while (wire_lvl !== 1'b1 && n < 4 * period + 64) begin
				@(negedge ref_clk);
				n++;
			end
			while (wire_lvl === 1'b1 && hi < period) begin
				@(negedge ref_clk);
				hi++;
			end
			// only the two documented high times are legal
			if (hi != period / 4 && hi != period - period / 4) ok = 1'b0;
			word[b] = (hi > period / 2);
		end
	endtask : read_word
endmodule : tafr_host_model

// ==== test/tb_thermal_average_filter_readout.sv ====
// tb_thermal_average_filter_readout: directed scenarios for the filter and its wire readout.
// assumes tafr_top and tafr_host_model; inputs change at the falling edge of ref_clk.
`timescale 1ns/1ps
module tb_thermal_average_filter_readout;
	import tafr_pkg::*;
	logic                     ref_clk;
	logic                     rst;
	tafr_sample_s             die_temp_sensor;
	logic                     thermal_limit_assert;
	logic                     shift_load;
	logic [SHIFT_W-1:0]       averaging_shift_constant;
	logic signed [TEMP_W-1:0] model_specific_register;
	logic signed [AVG_W-1:0]  avg_temp;
	tafr_link_s               thermal_sideband_wire;
	logic                     host_drv;
	logic                     wire_lvl;
	int                       fail_count = 0;
	int                       check_count = 0;

	assign wire_lvl = thermal_sideband_wire.oe ? thermal_sideband_wire.drv : host_drv;

	tafr_top DUT (
		.ref_clk                  (ref_clk),
		.rst                      (rst),
		.die_temp_sensor          (die_temp_sensor),
		.thermal_limit_assert     (thermal_limit_assert),
		.shift_load               (shift_load),
		.averaging_shift_constant (averaging_shift_constant),
		.model_specific_register  (model_specific_register),
		.avg_temp                 (avg_temp),
		.thermal_sideband_wire_in (wire_lvl),
		.thermal_sideband_wire    (thermal_sideband_wire)
	);

	tafr_host_model HOST (
		.ref_clk  (ref_clk),
		.wire_lvl (wire_lvl),
		.host_drv (host_drv)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic check_avg(input logic [15:0] a, input logic [15:0] m);
		check({{2{avg_temp[AVG_W-1]}}, avg_temp}, a, "average");
		check({{8{model_specific_register[TEMP_W-1]}}, model_specific_register}, m, "integer reading");
	endtask : check_avg

	task automatic sample(input logic signed [7:0] t, input logic lim);
		@(negedge ref_clk);
		die_temp_sensor = '{valid: 1'b1, temp: t};
		thermal_limit_assert = lim;
		@(negedge ref_clk);
		die_temp_sensor.valid = 1'b0;
	endtask : sample

	task automatic load(input logic [3:0] v);
		@(negedge ref_clk);
		shift_load = 1'b1;
		averaging_shift_constant = v;
		@(negedge ref_clk);
		shift_load = 1'b0;
	endtask : load

	task automatic t_walk();
		sample(8'sd20, 1'b0);
		check_avg(16'h0500, 16'h0014); // first sample seeds
		sample(8'sd0, 1'b0);
		check_avg(16'h04FB, 16'h0013); // default shift of eight, floor
	endtask : t_walk

	task automatic t_shift();
		load(4'h2);
		sample(8'sd24, 1'b0);
		check_avg(16'h053C, 16'h0014);
	endtask : t_shift

	task automatic t_throttle();
		load(4'h0);
		sample(8'sd1, 1'b0);
		check_avg(16'h0040, 16'h0001);
		load(4'h2);
		sample(8'sd30, 1'b1);
		check_avg(16'h0030, 16'h0000); // fraction only after throttle
		sample(8'sd30, 1'b1);
		check_avg(16'h0024, 16'h0000); // fraction falls toward zero
		sample(-8'sd5, 1'b0);
		check_avg(16'h002B, 16'h0000); // cool sample never drags below one
		sample(8'sd30, 1'b1);
		check_avg(16'h0020, 16'h0000); // negative step rounds down
	endtask : t_throttle

	task automatic t_wire(input int period, input logic [15:0] exp);
		logic [15:0] w;
		logic        ok;
		HOST.read_word(period, w, ok);
		check({15'h0000, ok}, 16'h0001, "bit high time");
		check(w, exp, "wire word");
		// decode ends at the fall of the last bit; its low tail and the enable drop follow
		repeat (period) @(negedge ref_clk);
		check({15'h0000, thermal_sideband_wire.oe}, 16'h0000, "wire released");
	endtask : t_wire

	initial begin
		rst = 1'b1;
		die_temp_sensor = '{valid: 1'b0, temp: 8'h00};
		thermal_limit_assert = 1'b0;
		shift_load = 1'b0;
		averaging_shift_constant = 4'h0;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		check_avg(16'h0000, 16'h0000);
		check({15'h0000, thermal_sideband_wire.oe}, 16'h0000, "idle wire");
		t_walk();
		t_shift();
		t_throttle();
		t_wire(8, 16'h0020);
		load(4'h0);
		sample(8'sd100, 1'b0);
		t_wire(12, 16'h1900); // average, not the raw 100
		end_of_test();
	end

	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		end_of_test();
	end
endmodule : tb_thermal_average_filter_readout
